// file: rtl/scu_regs.svh
`ifndef SCU_REGS_SVH
`define SCU_REGS_SVH
// register indices; byte address is four times the index
`define SCU_STATUS_IDX   8'h0E
`define SCU_CONFIG_IDX   8'h0F
`define SCU_RESP_OKAY    2'b00
`define SCU_RESP_SLVERR  2'b10
// status field positions
`define SCU_ST_BUF       0
`define SCU_ST_FRAME     1
`define SCU_ST_OVR       2
`define SCU_ST_PAR       3
`define SCU_ST_EARLY     4
`define SCU_ST_TO1       5
`define SCU_ST_STATUS_RST 8'h00
// config field positions
`define SCU_CF_MASK      0
`define SCU_CF_T1        1
`define SCU_CF_LCT       2
`define SCU_CF_PEL_LO    4
`define SCU_CF_RST       8'h00
// timing
`define SCU_CLK_PS       5000
`define SCU_RDCLR_PS     2000000
`define SCU_RDCLR_CYC    ((`SCU_RDCLR_PS + `SCU_CLK_PS - 1) / `SCU_CLK_PS)
`define SCU_BUFCLR_CYC   3
`define SCU_EA_IGNORE    200
`define SCU_EA_NMAX_A    384
`define SCU_EA_NMAX_B    368
`endif

// file: rtl/scu_pkg.sv
package scu_pkg;
	typedef enum logic {CLR_IDLE, CLR_WAIT} scu_clr_e;
	typedef logic [8:0] scu_cnt_t;
endpackage

// file: rtl/scu_status.sv
`timescale 1ns/1ps
`include "scu_regs.svh"
// Summary of operation
// - irq line low while any error or timeout flag is set
// - error and timeout flags (bits 1..7) seen by a status read clear 2 us after the read
// - buffer flag pulls irq low when its mask bit is clear
// - buffer flag clears 3 cycles after tx write or rx read, or on tx-to-rx
// - last character sent in last-char mode leaves transmit-empty unset
// - timeout flags at bits 5..7 set on counter terminal counts
// - early reply flag: first start bit in window 200..nmax low or <nmax high
// - every card reset toggle restarts the early reply windows
// - T=0 parity flag set when error count reaches or passes programmed limit
// - parity flag raised on the 10.5 or 11.5 ETU strobe
// - T=0 bad-parity character is not stored
// - T=1 bad-parity character is stored, counter idle
// - overrun flag set on new character while receive register full
// - frame flag set if line low at 10.25 ETU; cleared by status read
// - bit 0 means transmit empty in tx mode, receive full in rx mode
// - transmit empty set when next char writable, cleared on write or dir clear
// - receive full set at programmed FIFO depth, cleared by reads
// - read-only 8-bit status at index Eh, fields as listed, reset 0
// - limit code 000 means one error, 111 means eight
// - T=0 correct character resets the parity error counter
// - buffer mask set stops buffer events interrupting
module scu_status #(
	parameter bit REV_B = 1'b0
) (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        card_io_pin,
	input  wire logic        card_rst_pin,
	input  wire logic        card_clk_pin,
	input  wire logic        tx_mode,
	input  wire logic        tx_holding_wr,
	input  wire logic        rx_holding_rd,
	input  wire logic        tx_char_ready,
	input  wire logic        tx_last_char,
	input  wire logic        rx_fifo_at_depth,
	input  wire logic [2:0]  timeout_tc,
	input  wire logic        rx_char_strobe,
	input  wire logic        rx_parity_bad,
	input  wire logic        tx_nak_strobe,
	input  wire logic        rx_holding_full,
	input  wire logic        frame_check_strobe,
	output logic             rx_store_en,
	output logic             host_irq_n
);
	localparam logic [8:0] NMAX = REV_B ? 9'(`SCU_EA_NMAX_B) : 9'(`SCU_EA_NMAX_A);
	localparam logic [8:0] RDCLR = 9'(`SCU_RDCLR_CYC);

	logic [7:0] status_reg, status_next, config_reg, pend_reg;
	logic aw_full_reg, w_full_reg;
	logic [7:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic bvalid_reg, rvalid_reg, irq_n_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic [31:0] rdata_reg;
	scu_pkg::scu_clr_e clr_state_reg;
	scu_pkg::scu_cnt_t clr_cnt_reg, card_cnt_reg;
	logic [2:0] io_sync_reg, rst_sync_reg, cclk_sync_reg;
	logic ea_armed_reg, tx_mode_d_reg, rxfull_d_reg;
	logic [2:0] bufclr_reg;
	logic [3:0] perr_cnt_reg;

	// index decode: byte address must be word aligned and hit a known index
	function automatic logic hit(input logic [7:0] a, input logic [7:0] idx);
		hit = (a[1:0] == 2'h0) && (a[7:2] == idx[5:0]);
	endfunction

	// write and read address decode
	wire do_write  = aw_full_reg && w_full_reg && !bvalid_reg;
	wire wr_config = hit(aw_addr_reg, `SCU_CONFIG_IDX);
	wire do_read   = s_axi_arvalid && !rvalid_reg;
	wire rd_status = hit(s_axi_araddr, `SCU_STATUS_IDX);
	wire rd_config = hit(s_axi_araddr, `SCU_CONFIG_IDX);
	wire status_rd = do_read && rd_status;

	assign s_axi_awready = !aw_full_reg;
	assign s_axi_wready  = !w_full_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rresp   = rresp_reg;
	assign s_axi_rdata   = rdata_reg;
	assign host_irq_n    = irq_n_reg;

	// address and data channels are caught separately, in either order
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			aw_full_reg <= 1'b0;
			w_full_reg  <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg  <= 32'h0000_0000;
			w_strb_reg  <= 4'h0;
		end else begin
			if (s_axi_awvalid && !aw_full_reg) begin
				aw_full_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end else if (do_write) begin
				aw_full_reg <= 1'b0;
			end
			if (s_axi_wvalid && !w_full_reg) begin
				w_full_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end else if (do_write) begin
				w_full_reg <= 1'b0;
			end
		end
	end

	// write response; status is read only, so only config accepts data
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= `SCU_RESP_OKAY;
			config_reg <= `SCU_CF_RST;
		end else begin
			if (do_write) begin
				bvalid_reg <= 1'b1;
				bresp_reg  <= wr_config ? `SCU_RESP_OKAY : `SCU_RESP_SLVERR;
				if (wr_config && w_strb_reg[0])
					config_reg <= w_data_reg[7:0];
			end else if (s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// config as it stands after this edge, so irq follows a mask write without a stale cycle
	wire [7:0] config_next = (do_write && wr_config && w_strb_reg[0]) ? w_data_reg[7:0]
		: config_reg;

	// read data is the status seen at the address edge, before any clear
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			rvalid_reg <= 1'b0;
			rresp_reg  <= `SCU_RESP_OKAY;
			rdata_reg  <= 32'h0000_0000;
		end else if (do_read) begin
			rvalid_reg <= 1'b1;
			rresp_reg  <= (rd_status || rd_config) ? `SCU_RESP_OKAY : `SCU_RESP_SLVERR;
			rdata_reg  <= {24'h000000, rd_status ? status_reg
				: (rd_config ? config_reg : 8'h00)};
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	// pin synchronisers; stage 0 feeds stage 1 only, stage 2 is for edges
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			io_sync_reg   <= 3'h7;
			rst_sync_reg  <= 3'h0;
			cclk_sync_reg <= 3'h0;
		end else begin
			io_sync_reg   <= {io_sync_reg[1:0], card_io_pin};
			rst_sync_reg  <= {rst_sync_reg[1:0], card_rst_pin};
			cclk_sync_reg <= {cclk_sync_reg[1:0], card_clk_pin};
		end
	end

	wire io_low     = !io_sync_reg[1];
	wire start_edge = io_sync_reg[2] && !io_sync_reg[1];
	wire rst_toggle = rst_sync_reg[2] ^ rst_sync_reg[1];
	wire cclk_rise  = !cclk_sync_reg[2] && cclk_sync_reg[1];
	wire rst_high   = rst_sync_reg[1];

	// card clock count since last reset toggle; saturates past the window
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			card_cnt_reg <= 9'h000;
			ea_armed_reg <= 1'b1;
		end else if (rst_toggle) begin
			card_cnt_reg <= 9'h000;
			ea_armed_reg <= 1'b1;
		end else begin
			if (cclk_rise && card_cnt_reg != 9'h1FF)
				card_cnt_reg <= card_cnt_reg + 9'h001;
			if (start_edge && (rst_high || card_cnt_reg >= 9'(`SCU_EA_IGNORE)))
				ea_armed_reg <= 1'b0;
		end
	end

	// only the first counted start bit matters; activity before 200 card clocks is ignored while reset is low
	wire ea_low_hit  = !rst_high && card_cnt_reg >= 9'(`SCU_EA_IGNORE)
		&& card_cnt_reg < NMAX;
	wire ea_high_hit = rst_high && card_cnt_reg < NMAX;
	wire ea_set = start_edge && ea_armed_reg && (ea_low_hit || ea_high_hit);

	// parity counting: T=0 counts to the limit, T=1 flags at once
	wire       proto_t1  = config_reg[`SCU_CF_T1];
	wire [3:0] pe_limit  = {1'b0, config_reg[`SCU_CF_PEL_LO +: 3]} + 4'h1;
	wire       par_event = (rx_char_strobe && rx_parity_bad) || tx_nak_strobe;
	// compare is >= so a limit lowered in mid-count still fires instead of waiting for a wrap
	wire       par_hit   = par_event && (proto_t1 || perr_cnt_reg + 4'h1 >= pe_limit);
	assign rx_store_en = rx_char_strobe && (!rx_parity_bad || proto_t1);

	always_ff @(posedge clk) begin
		if (!reset_n)
			perr_cnt_reg <= 4'h0;
		else if (proto_t1)
			perr_cnt_reg <= 4'h0;
		else if (par_hit)
			perr_cnt_reg <= 4'h0;
		else if (par_event)
			perr_cnt_reg <= perr_cnt_reg + 4'h1;
		else if (rx_char_strobe)
			perr_cnt_reg <= 4'h0;
	end

	// buffer flag clear is delayed three cycles behind the data access
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			bufclr_reg    <= 3'h0;
			tx_mode_d_reg <= 1'b0;
			rxfull_d_reg  <= 1'b0;
		end else begin
			bufclr_reg    <= {bufclr_reg[1:0], tx_holding_wr || rx_holding_rd};
			tx_mode_d_reg <= tx_mode;
			rxfull_d_reg  <= rx_fifo_at_depth;
		end
	end

	wire buf_clr = bufclr_reg[`SCU_BUFCLR_CYC - 1] || (tx_mode_d_reg && !tx_mode);
	wire tx_set  = tx_mode && tx_char_ready
		&& !(config_reg[`SCU_CF_LCT] && tx_last_char);
	wire rx_set  = !tx_mode && rx_fifo_at_depth && !rxfull_d_reg;
	wire buf_set = tx_set || rx_set;

	// read-clear sequencer: flags latched at the read clear 2 us later
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			clr_state_reg <= scu_pkg::CLR_IDLE;
			clr_cnt_reg   <= 9'h000;
			pend_reg      <= 8'h00;
		end else if (status_rd) begin
			clr_state_reg <= scu_pkg::CLR_WAIT;
			clr_cnt_reg   <= RDCLR - 9'h001;
			pend_reg      <= pend_reg | {status_reg[7:1], 1'b0};
		end else begin
			case (clr_state_reg)
				scu_pkg::CLR_WAIT: begin
					if (clr_cnt_reg == 9'h000) begin
						clr_state_reg <= scu_pkg::CLR_IDLE;
						pend_reg      <= 8'h00;
					end else begin
						clr_cnt_reg <= clr_cnt_reg - 9'h001;
					end
				end
				default: clr_state_reg <= scu_pkg::CLR_IDLE;
			endcase
		end
	end

	wire [7:0] rd_clr = (clr_state_reg == scu_pkg::CLR_WAIT && clr_cnt_reg == 9'h000
		&& !status_rd) ? pend_reg : 8'h00;

	// status update: a set in the same cycle as its clear wins
	always_comb begin
		status_next = status_reg & ~rd_clr;
		if (buf_clr)
			status_next[`SCU_ST_BUF] = 1'b0;
		if (buf_set)
			status_next[`SCU_ST_BUF] = 1'b1;
		if (frame_check_strobe && io_low)
			status_next[`SCU_ST_FRAME] = 1'b1;
		if (rx_char_strobe && rx_holding_full)
			status_next[`SCU_ST_OVR] = 1'b1;
		if (par_hit)
			status_next[`SCU_ST_PAR] = 1'b1;
		if (ea_set)
			status_next[`SCU_ST_EARLY] = 1'b1;
		status_next[`SCU_ST_TO1 +: 3] = status_next[`SCU_ST_TO1 +: 3] | timeout_tc;
	end

	// irq is registered so the pin never glitches between flag updates
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			status_reg <= `SCU_ST_STATUS_RST;
			irq_n_reg  <= 1'b1;
		end else begin
			status_reg <= status_next;
			irq_n_reg  <= !(|status_next[7:1]
				|| (status_next[`SCU_ST_BUF] && !config_next[`SCU_CF_MASK]));
		end
	end

	// interrupt line against the flags it summarises
	a_irq_errors: assert property (@(posedge clk) disable iff (!reset_n)
		|status_reg[7:1] |-> !host_irq_n) else $error("irq high with error flag set");
	a_irq_masked: assert property (@(posedge clk) disable iff (!reset_n)
		(status_reg[7:1] == 7'h00 && config_reg[`SCU_CF_MASK]) |-> host_irq_n)
		else $error("masked buffer flag raised irq");
	a_irq_buffer: assert property (@(posedge clk) disable iff (!reset_n)
		(status_reg[0] && !config_reg[`SCU_CF_MASK]) |-> !host_irq_n)
		else $error("unmasked buffer flag left irq high");
	a_irq_release: assert property (@(posedge clk) disable iff (!reset_n)
		(status_reg == 8'h00) |-> host_irq_n) else $error("irq low with nothing pending");

	// flag set and clear timing, watched from the pins where possible
	a_timeout_set: assert property (@(posedge clk) disable iff (!reset_n)
		timeout_tc[1] |=> status_reg[6]) else $error("timeout two not flagged");
	a_buf_delay: assert property (@(posedge clk) disable iff (!reset_n)
		(rx_holding_rd && !tx_mode && !rx_fifo_at_depth) ##1 !rx_fifo_at_depth [*3]
		|=> !status_reg[0]) else $error("buffer flag not cleared three cycles on");
	a_dir_clear: assert property (@(posedge clk) disable iff (!reset_n)
		($fell(tx_mode) && !rx_fifo_at_depth) |=> !status_reg[0])
		else $error("direction switch left buffer flag set");
	a_buf_set: assert property (@(posedge clk) disable iff (!reset_n)
		(tx_mode && tx_char_ready && !config_reg[`SCU_CF_LCT]) |=> status_reg[0])
		else $error("transmit empty not set");
	a_rx_full: assert property (@(posedge clk) disable iff (!reset_n)
		(!tx_mode && $rose(rx_fifo_at_depth)) |=> status_reg[0])
		else $error("receive full not set");
	a_frame_set: assert property (@(posedge clk) disable iff (!reset_n)
		(frame_check_strobe && io_low) |=> status_reg[1])
		else $error("frame error not flagged");
	a_read_clear: assert property (@(posedge clk) disable iff (!reset_n)
		(status_rd && status_reg[5] && timeout_tc == 3'h0) ##1 (!status_rd
		&& timeout_tc == 3'h0) [*8] |=> status_reg[5])
		else $error("flag cleared too soon after read");
	a_overrun_set: assert property (@(posedge clk) disable iff (!reset_n)
		(rx_char_strobe && rx_holding_full) |=> status_reg[2])
		else $error("overrun not flagged");
	a_perr_bound: assert property (@(posedge clk) disable iff (!reset_n)
		perr_cnt_reg < 4'h8) else $error("parity count past eight");
	a_t1_store: assert property (@(posedge clk) disable iff (!reset_n)
		(proto_t1 && rx_char_strobe) |-> rx_store_en)
		else $error("T=1 character dropped");
	a_t0_drop: assert property (@(posedge clk) disable iff (!reset_n)
		(!proto_t1 && rx_parity_bad) |-> !rx_store_en)
		else $error("T=0 bad character stored");
	a_lct_hold: assert property (@(posedge clk) disable iff (!reset_n)
		(tx_mode && tx_char_ready && tx_last_char && config_reg[`SCU_CF_LCT]
		&& !status_reg[0]) |=> !status_reg[0]) else $error("last char set empty");
	a_early_stop: assert property (@(posedge clk) disable iff (!reset_n)
		(!ea_armed_reg && !rst_toggle) |=> !$rose(status_reg[4]))
		else $error("early flag after first start bit");
	a_early_window: assert property (@(posedge clk) disable iff (!reset_n)
		$rose(status_reg[4]) |-> $past(card_cnt_reg) < NMAX)
		else $error("early flag outside window");
	a_rd_slverr: assert property (@(posedge clk) disable iff (!reset_n)
		(do_read && !rd_status && !rd_config) |=> (s_axi_rresp == `SCU_RESP_SLVERR
		&& s_axi_rdata == 32'h0000_0000)) else $error("bad read address answered");

	c_irq_fall: cover property (@(posedge clk) disable iff (!reset_n) $fell(host_irq_n));
	c_buf_irq: cover property (@(posedge clk) disable iff (!reset_n) status_reg[0] && !host_irq_n);
	c_read_clear: cover property (@(posedge clk) disable iff (!reset_n) |rd_clr);
	c_parity: cover property (@(posedge clk) disable iff (!reset_n) par_hit && !proto_t1);
	c_early: cover property (@(posedge clk) disable iff (!reset_n) ea_set);
endmodule

// file: bench/scu_card_model.sv
`timescale 1ns/1ps
// card side: answers a reset toggle with a start bit after a set count of card clocks
module scu_card_model (
	input  wire logic       clk,
	input  wire logic       go,
	input  wire logic       rst_level,
	input  wire logic       hold_low,
	input  wire logic [9:0] start_cnt,
	output logic            card_io_pin,
	output logic            card_rst_pin,
	output logic            card_clk_pin,
	output logic            busy
);
	// line idles at its pull-up level, card clock stands still
	initial begin
		card_io_pin = 1'h1;
		card_rst_pin = 1'h0;
		card_clk_pin = 1'h0;
		busy = 1'h0;
	end
	// card clock at one eighth of clk, slower than the sampler's limit of a quarter
	always @(posedge clk) begin
		if (go) begin
			busy <= 1'h1;
			card_rst_pin <= rst_level;
			for (int i = 0; i < start_cnt + 4; i++) begin
				repeat (4) @(posedge clk);
				card_clk_pin <= 1'h1;
				card_io_pin <= (i < start_cnt);
				repeat (4) @(posedge clk);
				card_clk_pin <= 1'h0;
			end
			card_io_pin <= 1'h1;
			busy <= 1'h0;
		end else begin
			card_io_pin <= !hold_low;
		end
	end
endmodule

// file: bench/test_smartcard_uart_status_irq.sv
`timescale 1ns/1ps
`include "scu_regs.svh"
module test_smartcard_uart_status_irq;
	localparam logic [7:0] ST_A = `SCU_STATUS_IDX << 2;
	localparam logic [7:0] CF_A = `SCU_CONFIG_IDX << 2;
	localparam int         NMAX = `SCU_EA_NMAX_A;
	typedef struct {logic [2:0] tc; logic frm; logic overrun_flag; logic [7:0] st;} scu_row_s;
	logic        clk, reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, card_io_pin, card_rst_pin, card_clk_pin, tx_mode, tx_holding_wr;
	logic        rx_holding_rd, tx_char_ready, tx_last_char, rx_fifo_at_depth, rx_char_strobe;
	logic        rx_parity_bad, tx_nak_strobe, rx_holding_full, frame_check_strobe;
	logic        rx_store_en, host_irq_n, go, rst_level, hold_low, busy;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	logic [2:0]  timeout_tc;
	logic [9:0]  start_cnt;
	int          err_total = 0, samples_checked = 0, cyc = 0;
	logic        cfg_t1 = 1'h0;
	int          ean[4] = '{10, 100, NMAX + 8, 250};
	logic        ear[4] = '{1'h1, 1'h0, 1'h1, 1'h0};
	// one event per row: timeout pulses, frame check with line low, overrun
	scu_row_s    rows[5] = '{'{3'h1, 1'h0, 1'h0, 8'h20}, '{3'h2, 1'h0, 1'h0, 8'h40},
		'{3'h4, 1'h0, 1'h0, 8'h80}, '{3'h0, 1'h1, 1'h0, 8'h02}, '{3'h0, 1'h0, 1'h1, 8'h04}};

	scu_status i_dut (.clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .card_io_pin, .card_rst_pin, .card_clk_pin,
		.tx_mode, .tx_holding_wr, .rx_holding_rd, .tx_char_ready, .tx_last_char,
		.rx_fifo_at_depth, .timeout_tc, .rx_char_strobe, .rx_parity_bad, .tx_nak_strobe,
		.rx_holding_full, .frame_check_strobe, .rx_store_en, .host_irq_n);
	scu_card_model i_card (.clk, .go, .rst_level, .hold_low, .start_cnt, .card_io_pin,
		.card_rst_pin, .card_clk_pin, .busy);

	// 200 MHz clock
	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end
	task automatic test_done;
		$display("checked %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// a hang counts as a mismatch; the run needs about 11000 cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			err_total++;
			test_done;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// write: both channels offered together, each dropped once taken
	task automatic axi_wr(input logic [7:0] a, input logic [7:0] v);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, v};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
	endtask
	task automatic axi_rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		do begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask
	task automatic rd_st(input logic [7:0] e);
		axi_rd(ST_A);
		chk(d, {24'h000000, e});
		chk({30'h0, r}, {30'h0, `SCU_RESP_OKAY});
	endtask
	// irq is sampled after the edge's updates land
	task automatic ir(input logic e);
		#1;
		chk({31'h0, host_irq_n}, {31'h0, e});
		@(posedge clk);
	endtask
	task automatic rxc(input logic b);
		rx_parity_bad <= b;
		rx_char_strobe <= 1'h1;
		#1;
		chk({31'h0, rx_store_en}, {31'h0, !b | cfg_t1});
		@(posedge clk);
		rx_char_strobe <= 1'h0;
		@(posedge clk);
	endtask

	initial begin
		{reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, tx_mode, tx_holding_wr} = '0;
		{rx_holding_rd, tx_char_ready, tx_last_char, rx_fifo_at_depth, rx_char_strobe} = '0;
		{rx_parity_bad, tx_nak_strobe, rx_holding_full, frame_check_strobe, go} = '0;
		{rst_level, hold_low, timeout_tc, start_cnt, s_axi_awaddr, s_axi_araddr} = '0;
		{s_axi_bready, s_axi_rready, s_axi_wstrb, s_axi_wdata} = {2'h3, 4'hF, 32'h0};
		repeat (10) @(posedge clk);
		reset_n <= 1'h1;
		@(posedge clk);
		ir(1'h1);
		rd_st(8'h00);
		axi_wr(ST_A, 8'hFF);
		chk({30'h0, r}, {30'h0, `SCU_RESP_SLVERR});
		axi_rd(8'h20);
		chk({30'h0, r}, {30'h0, `SCU_RESP_SLVERR});
		rd_st(8'h00);
		$display("test reset done");
		foreach (rows[i]) begin
			hold_low <= rows[i].frm;
			repeat (4) @(posedge clk);
			{timeout_tc, frame_check_strobe} <= {rows[i].tc, rows[i].frm};
			{rx_char_strobe, rx_holding_full} <= {2{rows[i].overrun_flag}};
			@(posedge clk);
			{timeout_tc, frame_check_strobe, rx_char_strobe, rx_holding_full, hold_low} <= '0;
			ir(1'h0);
			rd_st(rows[i].st);
			repeat (394) @(posedge clk);
			ir(1'h0);
			repeat (5) @(posedge clk);
			ir(1'h1);
			rd_st(8'h00);
		end
		$display("test flags done");
		// buffer flag: set, read (kept), cleared three cycles after a holding write
		tx_mode <= 1'h1;
		@(posedge clk);
		tx_char_ready <= 1'h1;
		@(posedge clk);
		tx_char_ready <= 1'h0;
		ir(1'h0);
		rd_st(8'h01);
		tx_holding_wr <= 1'h1;
		@(posedge clk);
		tx_holding_wr <= 1'h0;
		repeat (2) @(posedge clk);
		ir(1'h0);
		ir(1'h1);
		axi_wr(CF_A, 8'h01);
		chk({30'h0, r}, {30'h0, `SCU_RESP_OKAY});
		tx_char_ready <= 1'h1;
		@(posedge clk);
		tx_char_ready <= 1'h0;
		@(posedge clk);
		ir(1'h1);
		rd_st(8'h01);
		tx_mode <= 1'h0;
		repeat (3) @(posedge clk);
		rd_st(8'h00);
		axi_wr(CF_A, 8'h04);
		tx_mode <= 1'h1;
		@(posedge clk);
		{tx_char_ready, tx_last_char} <= 2'h3;
		@(posedge clk);
		{tx_char_ready, tx_last_char} <= 2'h0;
		@(posedge clk);
		rd_st(8'h00);
		tx_mode <= 1'h0;
		@(posedge clk);
		rx_fifo_at_depth <= 1'h1;
		repeat (2) @(posedge clk);
		ir(1'h0);
		rd_st(8'h01);
		{rx_fifo_at_depth, rx_holding_rd} <= 2'h1;
		@(posedge clk);
		rx_holding_rd <= 1'h0;
		repeat (4) @(posedge clk);
		rd_st(8'h00);
		$display("test buffer done");
		// parity: limit code 111, a good character in mid-run restarts the count
		axi_wr(CF_A, 8'h70);
		for (int k = 0; k < 12; k++) begin
			rxc(k != 3);
			if (k == 10) rd_st(8'h00);
		end
		rd_st(8'h08);
		repeat (405) @(posedge clk);
		axi_wr(CF_A, 8'h00);
		tx_nak_strobe <= 1'h1;
		@(posedge clk);
		tx_nak_strobe <= 1'h0;
		@(posedge clk);
		rd_st(8'h08);
		repeat (405) @(posedge clk);
		tx_holding_wr <= 1'h1;
		@(posedge clk);
		tx_holding_wr <= 1'h0;
		rd_st(8'h00);
		axi_wr(CF_A, 8'h72);
		cfg_t1 = 1'h1;
		rxc(1'h1);
		rd_st(8'h08);
		repeat (405) @(posedge clk);
		$display("test parity done");
		// early reply: each start toggles card reset
		for (int k = 0; k < 4; k++) begin
			{rst_level, start_cnt, go} <= {ear[k], 10'(ean[k]), 1'h1};
			@(posedge clk);
			go <= 1'h0;
			@(posedge clk);
			while (busy) @(posedge clk);
			repeat (4) @(posedge clk);
			rd_st({3'h0, ear[k] ? ean[k] < NMAX : ean[k] >= 200 && ean[k] < NMAX, 4'h0});
			repeat (405) @(posedge clk);
		end
		$display("test early reply done");
		test_done;
	end
endmodule
